/* hw/csp_pkg.sv */
// Purpose: shared constants for the codec serial port
// Assumes: 40 MHz system clock
// Notes:   register offsets are word indices on the plain register port
package csp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CSP_ADDR_CTRL1  = 4'h0; // port_control_reg_one
  localparam logic [3:0] CSP_ADDR_CTRL2  = 4'h1; // frame, word, buffer length
  localparam logic [3:0] CSP_ADDR_CTRL3  = 4'h2; // bit clock divider
  localparam logic [3:0] CSP_ADDR_STAT   = 4'h3; // slot and buffer status
  localparam logic [3:0] CSP_ADDR_TXBUF0 = 4'h4; // transmit words 0..3 at 4..7
  localparam logic [3:0] CSP_ADDR_RXBUF0 = 4'h8; // receive words 0..3 at 8..11

  // ----------------------------------------------------------------
  // control register one fields
  // ----------------------------------------------------------------
  localparam int CSP_EN_BIT       = 15;
  localparam int CSP_LOOP_BIT     = 11;
  localparam int CSP_BCLK_DIR_BIT = 10;
  localparam int CSP_BCLK_EDGE_BIT= 9;
  localparam int CSP_FS_DIR_BIT   = 8;
  localparam int CSP_UNDER_BIT    = 7;
  localparam int CSP_IDLE_BIT     = 6;
  localparam int CSP_JUST_BIT     = 5;
  localparam int CSP_FSM_LSB      = 0;

  // ----------------------------------------------------------------
  // control register two fields
  // ----------------------------------------------------------------
  localparam int CSP_BLEN_LSB  = 10;
  localparam int CSP_FLEN_LSB  = 5;
  localparam int CSP_WS_LSB    = 0;

  // ----------------------------------------------------------------
  // reset values and modes
  // ----------------------------------------------------------------
  localparam logic [15:0] CSP_CTRL_RST = 16'h0000;
  localparam logic [11:0] CSP_DIV_RST  = 12'h000;
  localparam logic [1:0]  CSP_FSM_MULTI = 2'h0;
  localparam logic [1:0]  CSP_FSM_I2S   = 2'h1;
  localparam int          CSP_WORD_MAX  = 16;
  localparam int          CSP_DEPTH     = 4;

endpackage : csp_pkg

/* hw/csp_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: d is asynchronous to clk
// Notes:   only the second flop is visible
`timescale 1ns/10ps
module csp_sync
  import csp_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);

  typedef struct packed
  {
    logic s1;
    logic s2;
  } csp_sync_t;

  csp_sync_t st_r;
  csp_sync_t st_nxt;

  // shift the pin through two stages
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule : csp_sync

/* hw/csp_clkgen.sv */
// Purpose: bit clock generator for the codec serial port
// Assumes: divider value from control register three
// Notes:   bit clock period is 2*(div+1) system clocks
`timescale 1ns/10ps
module csp_clkgen
  import csp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic [11:0] div,
  output logic             bclk
);

  typedef struct packed
  {
    logic [11:0] cnt;
    logic        lvl;
  } csp_clkgen_t;

  csp_clkgen_t st_r;
  csp_clkgen_t st_nxt;

  // toggle the clock level each time the divider expires
  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      st_nxt.cnt = 12'h000;
      st_nxt.lvl = 1'b0;
    end
    else if (st_r.cnt >= div)
    begin
      st_nxt.cnt = 12'h000;
      st_nxt.lvl = ~st_r.lvl;
    end
    else
      st_nxt.cnt = st_r.cnt + 12'h001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bclk = st_r.lvl;

endmodule : csp_clkgen

/* hw/csp_port.sv */
// Purpose: codec serial port with framing, shift register and shadowed buffers
// Assumes: 40 MHz clk; bit clock far slower than clk when supplied from outside
// Notes:   register port: addr, wdata, wr, rd, rdata valid the cycle after rd
//
// Overview of operation
// R1: while enabled the port itself sets direction of all four pins
// R2: bit clock direction chosen by a bit in control register one
// R3: bit clock as output is generated here and driven onto its pin
// R4: bit clock as input must be supplied by the codec
// R5: serial output is output only and drives while data is sent
// R6: idle bit periods leave serial output tri-stated or low
// R7: serial input pin is input only while enabled
// R8: frame sync marks framing of both data lines for both parties
// R9: frame sync pin direction chosen by a bit in control register one
// R10: buffer words stored left justified, word msb at bit 15
// R11: short received words get zeros in unused low bits
// R12: short transmit words have unused low bits ignored
// R13: one 16-bit shift register, msb first
// R14: word length programmable up to 16 bits
// R15: up to 16 slots per frame, 256 bit clocks at most
// R16: up to four words buffered per direction between services
// R17: serial logic uses shadow buffers while cpu uses register copies
// R18: multi-channel, i2s and ac-link framing supported; only multi-channel and i2s are built, modes 10 and 11 frame as multi-channel
// R19: idle mode 1 tri-states output in unused slots, 0 drives low
// R20: frame sync direction 1 is input, 0 is output
// R21: frame sync mode 00 multi-channel, 01 i2s
// R22: external bit clock and frame sync synchronised before use
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module csp_port
  import csp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        bit_clock_pin_i,
  output logic             bit_clock_pin_o,
  output logic             bit_clock_pin_oe,
  input  wire logic        frame_sync_pin_i,
  output logic             frame_sync_pin_o,
  output logic             frame_sync_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [15:0]       ctrl1;
    logic [15:0]       ctrl2;
    logic [11:0]       div;
    logic [3:0][15:0]  tx_cpu;     // cpu side transmit words
    logic [3:0][15:0]  rx_cpu;     // cpu side receive words
    logic [3:0][15:0]  tx_sh;      // serial side shadow
    logic [3:0][15:0]  rx_sh;
    logic [15:0]       shreg;
    logic [15:0]       rdata;
    logic [3:0]        bitc;       // bit within slot
    logic [3:0]        slot;
    logic [1:0]        widx;       // buffer address counter
    logic              active;     // current slot carries data
    logic              pend;       // frame start waiting (delayed justify)
    logic              bclk_d;
    logic              fs_d;
    logic              sdo;
    logic              sdo_en;
    logic              fs_out;
    logic              rful;
    logic              rov;
    logic              tunf;
    logic              tmpty;
  } csp_port_t;

  csp_port_t st_r;
  csp_port_t st_nxt;

  logic       bclk_ext;
  logic       fs_ext;
  logic       sdi_s;
  logic       bclk_gen;
  logic       en;
  logic       bclk_in_mode;
  logic       fs_in_mode;
  logic       bclk;
  logic       fs;
  logic       rise;
  logic       fall;
  logic       tx_edge;
  logic       rx_edge;
  logic [3:0] ws;
  logic [3:0] flen;
  logic [1:0] blen;
  logic [1:0] fsm;
  logic       sdi;

  // mask keeping only the top ws+1 bits of a word
  function automatic logic [15:0] csp_mask(input logic [3:0] w);
    csp_mask = 16'hFFFF << (4'hF - w);
  endfunction : csp_mask

  // ----------------------------------------------------------------
  // pin synchronisers and clock generator
  // ----------------------------------------------------------------
  csp_sync u_sync_bclk (.clk(clk), .resetn(resetn), .d(bit_clock_pin_i), .q(bclk_ext));   // R22
  csp_sync u_sync_fs   (.clk(clk), .resetn(resetn), .d(frame_sync_pin_i), .q(fs_ext));   // R22
  csp_sync u_sync_sdi  (.clk(clk), .resetn(resetn), .d(serial_in_pin), .q(sdi_s));        // R7

  csp_clkgen u_clkgen
  (
    .clk    (clk),
    .resetn (resetn),
    .run    (en & ~bclk_in_mode),
    .div    (st_r.div),
    .bclk   (bclk_gen)
  );

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  assign en           = st_r.ctrl1[CSP_EN_BIT];
  assign bclk_in_mode = st_r.ctrl1[CSP_BCLK_DIR_BIT];                  // R2
  assign fs_in_mode   = st_r.ctrl1[CSP_FS_DIR_BIT];                    // R9
  assign fsm          = st_r.ctrl1[CSP_FSM_LSB +: 2];
  assign ws           = st_r.ctrl2[CSP_WS_LSB +: 4];                   // R14
  assign flen         = st_r.ctrl2[CSP_FLEN_LSB +: 4];                 // R15
  assign blen         = st_r.ctrl2[CSP_BLEN_LSB +: 2];                 // R16
  assign bclk         = bclk_in_mode ? bclk_ext : bclk_gen;            // R4
  assign fs           = fs_in_mode ? fs_ext : st_r.fs_out;             // R20
  assign rise         = bclk & ~st_r.bclk_d;
  assign fall         = ~bclk & st_r.bclk_d;
  assign tx_edge      = st_r.ctrl1[CSP_BCLK_EDGE_BIT] ? rise : fall;
  assign rx_edge      = st_r.ctrl1[CSP_BCLK_EDGE_BIT] ? fall : rise;
  assign sdi          = st_r.ctrl1[CSP_LOOP_BIT] ? st_r.sdo : sdi_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        fs_start;
    logic        last_bit;
    logic [15:0] rword;
    logic [3:0]  slot_n;
    fs_start = 1'b0;
    last_bit = 1'b0;
    rword    = 16'h0000;
    slot_n   = 4'h0;
    st_nxt   = st_r;
    st_nxt.bclk_d = bclk;
    st_nxt.fs_d   = fs;
    st_nxt.rdata  = 16'h0000;

    // register writes
    if (reg_wr)
    begin
      if (reg_addr == CSP_ADDR_CTRL1)
        st_nxt.ctrl1 = reg_wdata & 16'h8FE3;                            // R2 R9
      else if (reg_addr == CSP_ADDR_CTRL2)
        st_nxt.ctrl2 = reg_wdata & 16'h0DEF;
      else if (reg_addr == CSP_ADDR_CTRL3)
        st_nxt.div = reg_wdata[11:0];
      else if (reg_addr[3:2] == CSP_ADDR_TXBUF0[3:2])
      begin
        st_nxt.tx_cpu[reg_addr[1:0]] = reg_wdata;                       // R17
        st_nxt.tmpty = 1'b0;
      end
    end

    // register reads, answered next cycle
    if (reg_rd)
    begin
      if (reg_addr == CSP_ADDR_CTRL1)
        st_nxt.rdata = st_r.ctrl1;
      else if (reg_addr == CSP_ADDR_CTRL2)
        st_nxt.rdata = st_r.ctrl2;
      else if (reg_addr == CSP_ADDR_CTRL3)
        st_nxt.rdata = {4'h0, st_r.div};
      else if (reg_addr == CSP_ADDR_STAT)
        st_nxt.rdata = {4'h0, st_r.slot, 4'h0, st_r.rov, st_r.rful, st_r.tunf, st_r.tmpty};
      else if (reg_addr[3:2] == CSP_ADDR_TXBUF0[3:2])
        st_nxt.rdata = st_r.tx_cpu[reg_addr[1:0]];
      else if (reg_addr[3:2] == CSP_ADDR_RXBUF0[3:2])
      begin
        st_nxt.rdata = st_r.rx_cpu[reg_addr[1:0]];
        st_nxt.rful  = 1'b0;
      end
      else
        st_nxt.rdata = 16'h0000;
    end

    // frame start: external sync edge, or own generator at slot wrap
    if (fs_in_mode)
      fs_start = (fsm == CSP_FSM_I2S) ? (fs != st_r.fs_d) : (fs & ~st_r.fs_d); // R8 R21
    else
      fs_start = tx_edge & (st_r.slot == flen) & (st_r.bitc == 4'hF);          // R15

    if (!en)
    begin
      st_nxt.bitc   = 4'h0;
      st_nxt.slot   = 4'h0;
      st_nxt.widx   = 2'h0;
      st_nxt.sdo_en = 1'b0;
      st_nxt.active = 1'b0;
      st_nxt.fs_out = 1'b0;
      st_nxt.pend   = 1'b0;
    end
    else
    begin
      // delayed justify defers the frame one bit clock
      if (fs_start && st_r.ctrl1[CSP_JUST_BIT])
        st_nxt.pend = 1'b1;

      if (tx_edge)
      begin
        if ((fs_start && !st_r.ctrl1[CSP_JUST_BIT]) || st_r.pend)
        begin
          st_nxt.pend   = 1'b0;
          st_nxt.slot   = 4'h0;
          st_nxt.bitc   = 4'h0;
          st_nxt.widx   = 2'h0;
          st_nxt.active = 1'b1;
          st_nxt.tx_sh  = st_r.tx_cpu;                                   // R17
          st_nxt.tmpty  = 1'b1;
          st_nxt.shreg  = st_r.tx_cpu[0] & csp_mask(ws);                 // R12
        end
        else if (st_r.bitc == 4'hF)
        begin
          // slot boundary: next word from shadow
          slot_n        = st_r.slot + 4'h1;
          st_nxt.slot   = slot_n;
          st_nxt.bitc   = 4'h0;
          st_nxt.active = (slot_n <= flen) && (st_r.widx != blen);       // R16
          if (st_r.active && st_r.widx != blen)
            st_nxt.widx = st_r.widx + 2'h1;
          st_nxt.shreg  = st_r.tx_sh[st_r.widx + 2'h1] & csp_mask(ws);
        end
        else
        begin
          st_nxt.bitc  = st_r.bitc + 4'h1;
          st_nxt.shreg = {st_r.shreg[14:0], 1'b0};                       // R13
        end
        // data bits of active slot drive; otherwise idle mode
        st_nxt.sdo    = st_nxt.active && (st_nxt.bitc <= ws) && st_nxt.shreg[15];   // R5
        st_nxt.sdo_en = (st_nxt.active && (st_nxt.bitc <= ws))
                        || !st_r.ctrl1[CSP_IDLE_BIT];                    // R6 R19
        // own frame sync: high in first bit clock of frame, i2s level follows bit 0 of the slot number
        if (fsm == CSP_FSM_I2S)
          st_nxt.fs_out = st_nxt.slot[0];
        else
          st_nxt.fs_out = (st_nxt.slot == 4'h0) && (st_nxt.bitc == 4'h0);   // R8 R18
      end

      // capture received bits msb first into shadow, zero fill below
      if (rx_edge && st_r.active && st_r.bitc <= ws)
      begin
        rword    = st_r.rx_sh[st_r.widx];
        rword[4'hF - st_r.bitc] = sdi;                                    // R10
        last_bit = (st_r.bitc == ws);
        if (st_r.bitc == 4'h0)
          rword = {sdi, 15'h0000};                                        // R11
        st_nxt.rx_sh[st_r.widx] = rword;
        // last word of the block: hand shadows to cpu side
        if (last_bit && st_r.widx == blen)
        begin
          st_nxt.rx_cpu = st_nxt.rx_sh;                                   // R17
          st_nxt.rov    = st_r.rov | st_r.rful;
          st_nxt.rful   = 1'b1;
          st_nxt.tunf   = st_r.tunf | st_r.tmpty;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r       <= '0;
      st_r.ctrl1 <= CSP_CTRL_RST;
      st_r.ctrl2 <= CSP_CTRL_RST;
      st_r.div   <= CSP_DIV_RST;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // pins and read data
  // ----------------------------------------------------------------
  assign reg_rdata         = st_r.rdata;
  assign bit_clock_pin_o   = bclk_gen;                                  // R3
  assign bit_clock_pin_oe  = en & ~bclk_in_mode;                        // R1 R3
  assign frame_sync_pin_o  = st_r.fs_out;
  assign frame_sync_pin_oe = en & ~fs_in_mode;                          // R1 R20
  assign serial_out_pin_o  = st_r.sdo;
  assign serial_out_pin_oe = en & st_r.sdo_en;                          // R1 R5

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // frame start decoded again for the transmit mask check
  logic fs_start_dbg;
  assign fs_start_dbg = fs_in_mode ? ((fsm == CSP_FSM_I2S) ? (fs != st_r.fs_d) : (fs & ~st_r.fs_d))
                                   : (tx_edge & (st_r.slot == flen) & (st_r.bitc == 4'hF));

  a_bclk_dir: assert property (@(posedge clk) disable iff (!resetn) // R2
    bit_clock_pin_oe == (en && !st_r.ctrl1[CSP_BCLK_DIR_BIT])) else $error("bit clock direction wrong");
  a_fs_dir: assert property (@(posedge clk) disable iff (!resetn) // R20
    (en && st_r.ctrl1[CSP_FS_DIR_BIT]) |-> !frame_sync_pin_oe) else $error("frame sync driven as input");
  a_off_quiet: assert property (@(posedge clk) disable iff (!resetn) // R1
    !en |=> !st_r.sdo_en) else $error("serial out driven while off");
  a_idle_low: assert property (@(posedge clk) disable iff (!resetn) // R19
    (serial_out_pin_oe && !st_r.active) |-> !serial_out_pin_o) else $error("idle output not low");
  a_idle_tri: assert property (@(posedge clk) disable iff (!resetn) // R6
    (st_r.ctrl1[CSP_IDLE_BIT] && $stable(st_r.ctrl1) && !st_r.active && $past(!st_r.active)
     && $past(tx_edge)) |-> !serial_out_pin_oe) else $error("idle output not released");
  a_rd_data: assert property (@(posedge clk) disable iff (!resetn) // R17
    (reg_rd && reg_addr == CSP_ADDR_CTRL3) |=> reg_rdata == {4'h0, $past(st_r.div)})
    else $error("read data wrong");
  a_rx_zero: assert property (@(posedge clk) disable iff (!resetn) // R11
    (st_r.rful && $rose(st_r.rful)) |-> ((st_r.rx_cpu[0] & ~csp_mask(ws)) == 16'h0000))
    else $error("low bits not zero");
  a_tx_mask: assert property (@(posedge clk) disable iff (!resetn) // R12
    (tx_edge && st_r.bitc == 4'hF && en && !st_r.pend && !fs_start_dbg) |=>
    ((st_r.shreg & ~csp_mask(ws)) == 16'h0000)) else $error("unused tx bits shifted");

endmodule : csp_port

/* tb/csp_codec_model.sv */
// Purpose: behavioural codec that supplies bit clock, frame sync and serial data
// Assumes: 200 ns bit clock, frames of 32 bit clocks, sample one bit clock after sync
// Notes:   clock stands still between frames while run is low
`timescale 1ns/10ps
module csp_codec_model
(
  input  wire logic        run,
  input  wire logic [15:0] word,
  output logic             bclk,
  output logic             fsync,
  output logic             sdata,
  output logic             frame_done
);
  // ----------------------------------------------------------------
  // frame generator
  // ----------------------------------------------------------------
  // data and sync change on the falling edge; the word follows the sync by
  // one bit clock (delayed justify); outside the word the line stays driven
  // and toggles instead of keeping the last bit
  initial
  begin
    bclk       = 1'b0;
    fsync      = 1'b0;
    sdata      = 1'b0;
    frame_done = 1'b0;
    forever
    begin
      wait (run);
      for (int b = 0; b < 32; b++)
      begin
        fsync = (b == 0);
        sdata = (b >= 1 && b <= 16) ? word[16 - b] : ~sdata;
        #100 bclk = 1'b1;
        #100 bclk = 1'b0;
      end
      frame_done = 1'b1;
      #1 frame_done = 1'b0;
    end
  end
endmodule : csp_codec_model

/* tb/tb.sv */
// Purpose: self-checking bench for the codec serial port
// Assumes: 40 MHz clk, 200 ns external bit clock, loopback for transmit path
// Notes:   read results are queued by the driver and checked by a monitor
`timescale 1ns/10ps
module tb
  import csp_pkg::*;
;
  localparam logic [15:0] MST = 16'h8A80; // enable, loopback, rising transmit edge, repeat last
  logic        clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        bclk_o, bclk_oe, fs_o, fs_oe, sdo_o, sdo_oe;
  logic        cod_bclk, cod_fs, cod_sd, cod_done, run, rd_d;
  logic        bclk_w, fs_w;
  logic [15:0] exp_q[$];
  logic [15:0] pat, txw, msk;
  logic [3:0]  ws;
  int          n_errors, comparisons, n_frames, seed, c;

  // ----------------------------------------------------------------
  // wires of the shared pins and instances
  // ----------------------------------------------------------------
  assign bclk_w = bclk_oe ? bclk_o : cod_bclk;
  assign fs_w   = fs_oe ? fs_o : cod_fs;

  csp_port dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clock_pin_i(bclk_w),
    .bit_clock_pin_o(bclk_o), .bit_clock_pin_oe(bclk_oe), .frame_sync_pin_i(fs_w),
    .frame_sync_pin_o(fs_o), .frame_sync_pin_oe(fs_oe), .serial_in_pin(cod_sd),
    .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe));

  csp_codec_model codec_u (.run(run), .word(pat), .bclk(cod_bclk), .fsync(cod_fs),
    .sdata(cod_sd), .frame_done(cod_done));

  always #12.5 clk = ~clk;

  always @(posedge cod_done) n_frames++;

  // ----------------------------------------------------------------
  // compare and report tasks
  // ----------------------------------------------------------------
  task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : check_word

  task automatic check_count(input string nm, input int e, input int g);
    comparisons++;
    if (g != e)
    begin
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
      n_errors++;
    end
  endtask : check_count

  task automatic check_bit(input string nm, input logic e, input logic g);
    check_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask : check_bit

  task automatic summarize();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // read monitor: oldest note against data of the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
    begin
      if (exp_q.size() == 0)
        check_word("unexpected read", 16'hFFFF, reg_rdata);
      else
        check_word("register read", exp_q.pop_front(), reg_rdata);
    end
  end

  // ----------------------------------------------------------------
  // bus and timing tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : reg_read

  // sel 0 counts bit clock changes, 1 frame sync high, 2 serial out released
  task automatic count_cycles(input int sel, input int n, output int cnt);
    logic prev;
    cnt  = 0;
    prev = bclk_o;
    repeat (n)
    begin
      @(posedge clk);
      case (sel)
        0: cnt += (bclk_o !== prev);
        1: cnt += (fs_o === 1'b1);
        default: cnt += (sdo_oe !== 1'b1);
      endcase
      prev = bclk_o;
    end
  endtask : count_cycles

  task automatic wait_frames(input int n);
    int target;
    target = n_frames + n;
    for (int i = 0; i < 5000 && n_frames < target; i++)
      @(posedge clk);
    if (n_frames < target)
    begin
      $display("wrong value frame wait expected %0d seen %0d", target, n_frames);
      n_errors++;
      summarize();
    end
  endtask : wait_frames

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0; resetn = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; run = 1'b0; pat = 16'h0000;
    seed = 32'h3DC313E9;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // reset values, unimplemented bits, unmapped places
    reg_read(CSP_ADDR_CTRL1, CSP_CTRL_RST);
    reg_read(CSP_ADDR_CTRL3, {4'h0, CSP_DIV_RST});
    reg_write(CSP_ADDR_CTRL1, 16'h7FFF);
    reg_read(CSP_ADDR_CTRL1, 16'h0FE3);
    reg_write(CSP_ADDR_CTRL2, 16'hFFFF);
    reg_read(CSP_ADDR_CTRL2, 16'h0DEF);
    reg_write(CSP_ADDR_CTRL3, 16'hFFFF);
    reg_read(CSP_ADDR_CTRL3, 16'h0FFF);
    reg_write(4'hD, 16'hFFFF);
    reg_read(4'hD, 16'h0000);
    check_bit("oe while disabled", 1'b0, bclk_oe | fs_oe | sdo_oe);
    // master mode with loopback, random word of 4 to 16 bits
    ws  = 4'(3 + ($unsigned($random(seed)) % 13));
    msk = 16'hFFFF << (15 - ws);
    txw = 16'($random(seed));
    reg_write(CSP_ADDR_CTRL3, 16'h0003);
    reg_write(CSP_ADDR_CTRL2, 16'h0020 | {12'h000, ws});
    reg_write(CSP_ADDR_TXBUF0, txw);
    reg_write(CSP_ADDR_CTRL1, MST);
    repeat (20) @(posedge clk);
    check_bit("bclk oe", 1'b1, bclk_oe);
    check_bit("fs oe", 1'b1, fs_oe);
    count_cycles(0, 64, c);
    check_count("bclk edges", 16, c);
    count_cycles(2, 256, c);
    check_count("sdo released", 0, c);
    repeat (800) @(posedge clk);
    reg_read(CSP_ADDR_RXBUF0, txw & msk);
    // every frame sync mode with tri-state idle
    for (int m = 0; m < 4; m++)
    begin
      reg_write(CSP_ADDR_CTRL1, MST | 16'h0040 | 16'(m));
      repeat (300) @(posedge clk);
      count_cycles(1, 256, c);
      if (m == 1)
        check_bit("i2s fs wide", 1'b1, c > 8);
      else
        check_count("fs pulse", 8, c);
    end
    count_cycles(2, 256, c);
    check_bit("sdo tristate", 1'b1, c > 0);
    reg_write(CSP_ADDR_CTRL1, 16'h0000);
    repeat (4) @(posedge clk);
    check_bit("oe after disable", 1'b0, bclk_oe | fs_oe | sdo_oe);
    // slave mode: codec supplies clock, sync and data
    pat <= 16'($random(seed));
    reg_write(CSP_ADDR_CTRL1, 16'h85A0);
    run <= 1'b1;
    wait_frames(3);
    check_bit("bclk input", 1'b0, bclk_oe);
    check_bit("fs input", 1'b0, fs_oe);
    reg_read(CSP_ADDR_RXBUF0, pat & msk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : tb
